/* pmicir_host_model.sv */
`timescale 1ns/100ps
module pmicir_host_model (
  input wire logic clk, // System clock.
  input wire logic [7:0] regRdata, // Read data.
  input wire logic regRvalid, // Read data valid pulse.
  output logic [7:0] regAddr, // Register address.
  output logic regWrite, // Write strobe.
  output logic [7:0] regWdata, // Write data.
  output logic regRead // Read strobe.
);
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regWdata = 8'h00;
    regRead = 1'b0;
  end
  // Writing a one acknowledges a flag; this task issues one write strobe to the given address, which may be the cause register.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(posedge clk);
    #1;
    regWrite = 1'b0;
    regWdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    #1;
    regAddr = a;
    regRead = 1'b1;
    @(posedge clk);
    #1;
    regRead = 1'b0;
    @(posedge clk);
    #1;
    d = regRdata;
    v = regRvalid;
  endtask
endmodule

/* pmicir_id_rom.sv */
`timescale 1ns/100ps
module pmicir_id_rom #(
  parameter logic [11:0] VARIANT_CODE = 12'h5A5, // Arbitrary value.
  parameter logic [1:0] SILICON_REVISION = 2'h1, // Arbitrary value.
  parameter logic [1:0] CFG_VARIANT = pmicir_pkg::CFG_VARIANT_A
) (
  input wire logic clk, // System clock.
  input wire logic sel, // Selects which identification word.
  output logic [7:0] data // Registered identification byte.
);
  always_ff @(posedge clk) begin
    if (sel) begin
      data <= {SILICON_REVISION, CFG_VARIANT, VARIANT_CODE[11:8]};
    end else begin
      data <= VARIANT_CODE[7:0];
    end
  end
endmodule

/* pmicir_pkg.sv */
package pmicir_pkg;
  localparam logic [7:0] ADDR_VARIANT_LOW = 8'h00;
  localparam logic [7:0] ADDR_REV_VARIANT_HIGH = 8'h01;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h02;
  localparam logic [7:0] ADDR_IRQ_MASKS = 8'h03;
  localparam logic [7:0] ADDR_THERMAL_LIVE = 8'h04;
  localparam logic [7:0] ADDR_SHUTDOWN_CAUSE = 8'h05;
  localparam int FAULT_BIT = 7;
  localparam int SHUTDOWN_BIT = 3;
  localparam int DIE_HOT_BIT = 0;
  localparam int CAUSE_CRIT_BIT = 0;
  localparam int CAUSE_RAIL_BIT = 1;
  localparam int CAUSE_UV_BIT = 2;
  localparam int CAUSE_COLDOFF_BIT = 3;
  localparam logic [7:0] IRQ_FLAGS_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASKS_RESET = 8'hFF;
  localparam logic [7:0] IRQ_WRITABLE = 8'h89;
  localparam logic [7:0] CAUSE_WRITABLE = 8'h0F;
  localparam logic [7:0] SHUTDOWN_CAUSE_RESET = 8'h00;
  localparam logic [7:0] THERMAL_LIVE_RESET = 8'h00;
  localparam logic [1:0] CFG_VARIANT_A = 2'h0;
  localparam logic [1:0] CFG_VARIANT_B = 2'h1;
  localparam logic [1:0] CFG_VARIANT_C = 2'h2;
  localparam logic [1:0] CFG_VARIANT_D = 2'h3;
endpackage

/* pmicir_regs.sv */
`timescale 1ns/100ps
// How it works
// (R1) First identification register holds the low variant code as two nibbles.
// (R2) Second holds revision 7:6, configuration variant 5:4, upper variant nibble 3:0.
// (R3) Fault flag bit 7 sets on any rail power fault or critical temperature.
// (R4) Flags stay set until the host writes one to the bit.
// (R5) Shutdown flag bit 3 sets whenever the device shuts down.
// (R6) Shutdown flag cannot clear while any shutdown-cause bit is set.
// (R7) Die-hot flag bit 0 sets on an upward crossing of the hot threshold.
// (R8) Mask bits share flag positions, one means masked, reset all ones.
// (R9) Status bit 0 shows the live die-hot level, not latched.
// (R10) Interrupt register resets to zero; reserved bits are read-only zero.
// (R11) Setting any shutdown-cause bit also sets the shutdown flag.
// (R12) Interrupt output is active while any unmasked flag is set.
module pmicir_regs #(
  parameter logic [11:0] VARIANT_CODE = 12'h5A5, // Arbitrary value.
  parameter logic [1:0] SILICON_REVISION = 2'h1, // Arbitrary value.
  parameter logic [1:0] CFG_VARIANT = pmicir_pkg::CFG_VARIANT_A
) (
  input wire logic clk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic [7:0] regAddr, // Register address from the serial engine.
  input wire logic regWrite, // One-cycle write strobe.
  input wire logic [7:0] regWdata, // Write data.
  input wire logic regRead, // One-cycle read strobe.
  output logic [7:0] regRdata, // Read data, valid two cycles after regRead.
  output logic regRvalid, // Read data valid pulse.
  input wire logic railPowerFault, // Level: some rail has a power fault.
  input wire logic railFaultUnmasked, // Pulse: unmasked power fault shut the device down.
  input wire logic dieCritical, // Level: die above critical threshold.
  input wire logic dieHot, // Level: die above hot threshold.
  input wire logic supplyUndervoltage, // Pulse: supply fell below 5.4 V, shut down.
  input wire logic shutdownEvent, // Pulse: device shut itself down.
  output logic irqOut, // Interrupt, active high.
  output logic shutdownCausePending // Any shutdown-cause bit set.
);
  logic [7:0] irqFlags;
  logic [7:0] irqMasks;
  logic [7:0] shutdownCause;
  logic [7:0] idData;
  logic dieHotLive;
  logic dieHotPrev;
  logic dieCritPrev;
  logic railFaultPrev;
  logic idSel;
  logic [7:0] readAddr;
  logic readPend;
  logic [7:0] next_irqFlags;
  logic [7:0] next_cause;
  logic [7:0] next_irqMasks;
  logic [7:0] causeSet;

  function automatic logic hitWrite(input logic [7:0] a, input logic [7:0] target,
                                    input logic wr);
    hitWrite = wr && (a == target);
  endfunction

  pmicir_id_rom #(
    .VARIANT_CODE(VARIANT_CODE),
    .SILICON_REVISION(SILICON_REVISION),
    .CFG_VARIANT(CFG_VARIANT)
  ) idRom (
    .clk(clk),
    .sel(idSel),
    .data(idData)
  );

  assign idSel = (regAddr == pmicir_pkg::ADDR_REV_VARIANT_HIGH); // R1 R2

  // Edge history for the crossing detectors.
  always_ff @(posedge clk) begin
    if (srst) begin
      dieHotPrev <= 1'b0;
      dieCritPrev <= 1'b0;
      railFaultPrev <= 1'b0;
      dieHotLive <= 1'b0;
    end else begin
      dieHotPrev <= dieHot;
      dieCritPrev <= dieCritical;
      railFaultPrev <= railPowerFault;
      dieHotLive <= dieHot; // R9
    end
  end

  always_comb begin
    causeSet = 8'h00;
    causeSet[pmicir_pkg::CAUSE_UV_BIT] = supplyUndervoltage;
    causeSet[pmicir_pkg::CAUSE_RAIL_BIT] = railFaultUnmasked;
    causeSet[pmicir_pkg::CAUSE_CRIT_BIT] = dieCritical & ~dieCritPrev;
    next_cause = shutdownCause;
    if (hitWrite(regAddr, pmicir_pkg::ADDR_SHUTDOWN_CAUSE, regWrite)) begin
      next_cause = next_cause & ~(regWdata & pmicir_pkg::CAUSE_WRITABLE);
    end
    next_cause = next_cause | causeSet;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      shutdownCause <= pmicir_pkg::SHUTDOWN_CAUSE_RESET;
    end else begin
      shutdownCause <= next_cause;
    end
  end

  always_comb begin
    next_irqFlags = irqFlags;
    if (hitWrite(regAddr, pmicir_pkg::ADDR_IRQ_FLAGS, regWrite)) begin
      next_irqFlags = next_irqFlags & ~(regWdata & pmicir_pkg::IRQ_WRITABLE); // R4 R10
      if (shutdownCause != 8'h00) begin
        next_irqFlags[pmicir_pkg::SHUTDOWN_BIT] = irqFlags[pmicir_pkg::SHUTDOWN_BIT]; // R6
      end
    end
    // Sets win over a simultaneous clear.
    if ((railPowerFault & ~railFaultPrev) | (dieCritical & ~dieCritPrev)) begin
      next_irqFlags[pmicir_pkg::FAULT_BIT] = 1'b1; // R3
    end
    if (shutdownEvent | (causeSet != 8'h00)) begin
      next_irqFlags[pmicir_pkg::SHUTDOWN_BIT] = 1'b1; // R5 R11
    end
    if (dieHot & ~dieHotPrev) begin
      next_irqFlags[pmicir_pkg::DIE_HOT_BIT] = 1'b1; // R7
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irqFlags <= pmicir_pkg::IRQ_FLAGS_RESET; // R10
    end else begin
      irqFlags <= next_irqFlags;
    end
  end

  always_comb begin
    next_irqMasks = irqMasks;
    if (hitWrite(regAddr, pmicir_pkg::ADDR_IRQ_MASKS, regWrite)) begin
      next_irqMasks = (regWdata & pmicir_pkg::IRQ_WRITABLE) | ~pmicir_pkg::IRQ_WRITABLE; // R8
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irqMasks <= pmicir_pkg::IRQ_MASKS_RESET; // R8
    end else begin
      irqMasks <= next_irqMasks;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irqOut <= 1'b0;
      shutdownCausePending <= 1'b0;
    end else begin
      irqOut <= |(next_irqFlags & ~next_irqMasks); // R12
      shutdownCausePending <= (next_cause != 8'h00);
    end
  end

  // Reads are answered two cycles later so the registered ID bytes line up with the rest.
  always_ff @(posedge clk) begin
    if (srst) begin
      readPend <= 1'b0;
      readAddr <= 8'h00;
    end else begin
      readPend <= regRead;
      readAddr <= regAddr;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata <= 8'h00;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= readPend;
      if (readPend) begin
        case (readAddr)
          pmicir_pkg::ADDR_VARIANT_LOW: regRdata <= idData; // R1
          pmicir_pkg::ADDR_REV_VARIANT_HIGH: regRdata <= idData; // R2
          pmicir_pkg::ADDR_IRQ_FLAGS: regRdata <= irqFlags;
          pmicir_pkg::ADDR_IRQ_MASKS: regRdata <= irqMasks;
          pmicir_pkg::ADDR_THERMAL_LIVE: regRdata <= {7'h00, dieHotLive}; // R9
          pmicir_pkg::ADDR_SHUTDOWN_CAUSE: regRdata <= shutdownCause;
          default: regRdata <= 8'h00;
        endcase
      end
    end
  end

  AST_IRQ_RESET_ZERO: assert property (@(posedge clk) $past(srst) |-> irqFlags == 8'h00) // R10
    else $error("interrupt flags not zero after reset");
  AST_MASK_RESET_ONES: assert property (@(posedge clk) $past(srst) |-> irqMasks == 8'hFF) // R8
    else $error("masks not all ones after reset");
  AST_DIE_HOT_SETS: assert property (@(posedge clk) disable iff (srst)
    (dieHot && !dieHotPrev) |=> irqFlags[0]) // R7
    else $error("die-hot flag missed upward crossing");
  AST_FAULT_SETS: assert property (@(posedge clk) disable iff (srst)
    (dieCritical && !dieCritPrev) |=> irqFlags[7]) // R3
    else $error("fault flag missed critical crossing");
  AST_SHUTDOWN_SETS: assert property (@(posedge clk) disable iff (srst)
    shutdownEvent |=> irqFlags[3]) // R5
    else $error("shutdown flag missed shutdown event");
  AST_CAUSE_SETS_SHUTDOWN: assert property (@(posedge clk) disable iff (srst)
    supplyUndervoltage |=> irqFlags[3] && shutdownCause[2]) // R11
    else $error("cause did not set shutdown flag");
  AST_SHUTDOWN_HELD: assert property (@(posedge clk) disable iff (srst)
    (irqFlags[3] && shutdownCause != 8'h00) |=> irqFlags[3]) // R6
    else $error("shutdown flag cleared with cause pending");
  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (srst)
    (irqFlags[0] && !(regWrite && regAddr == 8'h02 && regWdata[0])) |=> irqFlags[0]) // R4
    else $error("die-hot flag dropped without clear");
  AST_IRQ_OUT: assert property (@(posedge clk) disable iff (srst)
    ##1 irqOut == |(irqFlags & ~irqMasks)) // R12
    else $error("interrupt output disagrees with flags");
  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (srst)
    (irqFlags & 8'h76) == 8'h00) // R10
    else $error("reserved interrupt bit set");
endmodule

/* pmicir_regs_tb.sv */
`timescale 1ns/100ps
module pmicir_regs_tb;
  logic clk, srst, regWrite, regRead, regRvalid, irqOut, pend, v;
  logic [7:0] regAddr, regWdata, regRdata, d;
  logic [5:0] ev;
  int nFail = 0;
  int nCompared = 0;
  logic [5:0] evs[6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
  logic [7:0] flg[6] = '{8'h80, 8'h08, 8'h88, 8'h01, 8'h08, 8'h08};
  logic [7:0] cse[6] = '{8'h00, 8'h02, 8'h01, 8'h00, 8'h04, 8'h00};
  pmicir_regs #(.VARIANT_CODE(12'h3C7), .SILICON_REVISION(2'h2),
    .CFG_VARIANT(pmicir_pkg::CFG_VARIANT_C)) pmicir_regs_i (.clk(clk), .srst(srst), .regAddr(regAddr),
    .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead), .regRdata(regRdata),
    .regRvalid(regRvalid), .railPowerFault(ev[5]), .railFaultUnmasked(ev[4]),
    .dieCritical(ev[3]), .dieHot(ev[2]), .supplyUndervoltage(ev[1]),
    .shutdownEvent(ev[0]), .irqOut(irqOut), .shutdownCausePending(pend));
  pmicir_host_model pmicir_host_model_i (.clk(clk), .regRdata(regRdata),
    .regRvalid(regRvalid), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRead(regRead));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nFail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    pmicir_host_model_i.rd(a, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask
  task automatic pulse(input logic [5:0] e);
    @(posedge clk);
    #1;
    ev = e;
    @(posedge clk);
    #1;
    ev = 6'h00;
    repeat (2) @(posedge clk);
  endtask
  task automatic results();
    $display("compared %0d failed %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    nFail++;
    results();
  end
  initial begin
    srst = 1'b1;
    ev = 6'h00;
    repeat (6) @(posedge clk);
    #1;
    srst = 1'b0;
    rdchk(pmicir_pkg::ADDR_IRQ_FLAGS, 8'h00);
    rdchk(pmicir_pkg::ADDR_IRQ_MASKS, 8'hFF);
    rdchk(pmicir_pkg::ADDR_THERMAL_LIVE, 8'h00);
    rdchk(8'h10, 8'h00);
    rdchk(pmicir_pkg::ADDR_VARIANT_LOW, 8'hC7);
    rdchk(pmicir_pkg::ADDR_REV_VARIANT_HIGH, 8'hA3);
    for (int i = 0; i < 6; i++) begin
      pulse(evs[i]);
      rdchk(pmicir_pkg::ADDR_IRQ_FLAGS, flg[i]);
      rdchk(pmicir_pkg::ADDR_SHUTDOWN_CAUSE, cse[i]);
      pmicir_host_model_i.wr(pmicir_pkg::ADDR_SHUTDOWN_CAUSE, 8'h0F);
      pmicir_host_model_i.wr(pmicir_pkg::ADDR_IRQ_FLAGS, 8'hFF);
      rdchk(pmicir_pkg::ADDR_IRQ_FLAGS, 8'h00);
    end
    pulse(6'h02);
    chk({7'h00, pend}, 8'h01);
    pmicir_host_model_i.wr(pmicir_pkg::ADDR_IRQ_FLAGS, 8'h08);
    rdchk(pmicir_pkg::ADDR_IRQ_FLAGS, 8'h08);
    pmicir_host_model_i.wr(pmicir_pkg::ADDR_SHUTDOWN_CAUSE, 8'h04);
    pmicir_host_model_i.wr(pmicir_pkg::ADDR_IRQ_FLAGS, 8'h08);
    rdchk(pmicir_pkg::ADDR_IRQ_FLAGS, 8'h00);
    pmicir_host_model_i.wr(pmicir_pkg::ADDR_IRQ_MASKS, 8'hF7);
    rdchk(pmicir_pkg::ADDR_IRQ_MASKS, 8'hF7);
    pulse(6'h01);
    chk({7'h00, irqOut}, 8'h01);
    pmicir_host_model_i.wr(pmicir_pkg::ADDR_IRQ_MASKS, 8'h00);
    rdchk(pmicir_pkg::ADDR_IRQ_MASKS, 8'h76);
    pmicir_host_model_i.wr(pmicir_pkg::ADDR_IRQ_FLAGS, 8'h08);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, irqOut}, 8'h00);
    ev = 6'h04;
    rdchk(pmicir_pkg::ADDR_THERMAL_LIVE, 8'h01);
    ev = 6'h00;
    rdchk(pmicir_pkg::ADDR_THERMAL_LIVE, 8'h00);
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    rdchk(pmicir_pkg::ADDR_IRQ_FLAGS, 8'h00);
    rdchk(pmicir_pkg::ADDR_IRQ_MASKS, 8'hFF);
    results();
  end
endmodule
